// File: dv/isb_card.sv
`include "isb_cfg.svh"

module isb_card (
  input  wire logic                 clk_sys,
  input  wire logic [`ISB_SA_W-1:0] sa,
  input  wire logic                 sbhe_n,
  input  wire logic                 aen,
  input  wire logic                 iorc_n,
  input  wire logic                 iowc_n,
  input  wire logic                 mrdc_n,
  input  wire logic                 mwtc_n,
  input  wire logic [`ISB_DW-1:0]   d_out,
  input  wire logic [7:0]           dak_n,
  input  wire logic [4:0]           slow,
  input  wire logic [7:0]           drq_set,
  output logic      [`ISB_DW-1:0]   d_in,
  output logic                      chrdy,
  output logic                      io16_n,
  output logic      [7:0]           drq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [16];
  logic [15:0] last_q = 16'h0000;
  logic [7:0]  pend_q = 8'h00;
  logic        cmd_q  = 1'b0;
  int          wait_q = 0;
  wire         rd   = !iorc_n || !mrdc_n;
  wire         wr   = !iowc_n || !mwtc_n;
  wire         wide = !io16_n && !sbhe_n;
  wire  [3:0]  a    = sa[3:0];

  // word-wide card sits at one io block
  assign io16_n = !(!aen && sa[19:4] == 16'h0030);
  // undriven lanes show the inverse of their last value
  assign d_in = rd ? {wide ? mem[a + 4'h1] : ~last_q[15:8], mem[a]} : ~last_q;
  // slow is five bits, so the stretch stays below 32 bus clocks
  assign chrdy = !(rd || wr) || slow == 5'h00 || (cmd_q && wait_q == 0);
  assign drq = pend_q;

  always @(posedge clk_sys) begin
    last_q <= d_in;
    cmd_q <= rd || wr;
    if ((rd || wr) && !cmd_q) wait_q <= 8 * slow;
    else if (wait_q > 0) wait_q <= wait_q - 1;
    if (wr && !aen) begin
      mem[a] <= d_out[7:0];
      if (wide) mem[a + 4'h1] <= d_out[15:8];
    end
    pend_q <= (pend_q | drq_set) & dak_n;
  end
endmodule : isb_card

// File: dv/isb_host_monitor.sv
`include "isb_cfg.svh"

module isb_host_monitor (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 iochk_n,
  input wire logic                 sys_err,
  input wire logic                 bclk,
  input wire logic                 resdrv,
  input wire logic                 bale,
  input wire logic                 aen,
  input wire logic [`ISB_SA_W-1:0] sa,
  input wire logic                 sbhe_n,
  input wire logic                 iorc_n,
  input wire logic                 iowc_n,
  input wire logic                 mrdc_n,
  input wire logic                 mwtc_n,
  input wire logic [7:0]           dak_n,
  input wire logic                 d_oe_n,
  input wire logic [7:0]           drq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire [3:0] strb_n = {iorc_n, iowc_n, mrdc_n, mwtc_n};

  dma_owns_a: assert property (aen == (dak_n != 8'hFF))
    else $error("aen disagrees with dma acknowledge");
  bale_dma_a: assert property (aen |-> bale)
    else $error("bale low during dma");
  addr_stable_a: assert property ((strb_n != 4'hF) && !aen |-> !bale && $stable(sa))
    else $error("address moved during command");
  bclk_duty_a: assert property ($rose(bclk) |-> bclk [*4] ##1 !bclk [*4] ##1 bclk)
    else $error("bus clock not four high four low");
  strobe_rise_a: assert property ($changed(strb_n) |-> $rose(bclk))
    else $error("strobe changed off a bus clock rise");
  one_ack_a: assert property ($onehot0(~dak_n) && dak_n[4])
    else $error("more than one acknowledge");
  grant_prio_a: assert property ((dak_n != 8'hFF) && $past(dak_n) == 8'hFF |->
      ((~dak_n & drq) != 8'h00) && (((~dak_n) - 8'h01) & $past(drq, 2) & $past(drq, 3)
      & $past(drq, 4)) == 8'h00)
    else $error("grant without request or to lower channel");
  dma_width_a: assert property ((dak_n != 8'hFF) |-> sbhe_n == (dak_n[3:0] != 4'hF))
    else $error("dma width wrong for channel");
  io_read_a: assert property (!iorc_n |-> iowc_n && (aen || d_oe_n))
    else $error("board drives data on io read");
  io_write_a: assert property (!iowc_n && !aen |-> !d_oe_n)
    else $error("board not driving data on io write");
  chk_error_a: assert property (!iochk_n [*4] |-> sys_err)
    else $error("channel check not latched");
  reset_quiet_a: assert property (resdrv |-> strb_n == 4'hF && dak_n == 8'hFF && !bale)
    else $error("bus active during reset drive");
endmodule : isb_host_monitor

bind isb_host isb_host_monitor isb_host_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .iochk_n(iochk_n), .sys_err(sys_err), .bclk(bclk),
  .resdrv(resdrv), .bale(bale), .aen(aen), .sa(sa), .sbhe_n(sbhe_n), .iorc_n(iorc_n),
  .iowc_n(iowc_n), .mrdc_n(mrdc_n), .mwtc_n(mwtc_n), .dak_n(dak_n), .d_oe_n(d_oe_n),
  .drq(drq));

// File: dv/isb_host_test.sv
`include "isb_cfg.svh"

module isb_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  import isb_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, irq_ack = 1'b0, err_clr = 1'b0;
  logic iochk_n = 1'b1, dma_to_mem = 1'b1;
  logic [`ISB_AW-1:0] dma_addr = 24'h000300;
  logic [15:0] irq = 16'h0000, d_out, d_in;
  logic [7:0] drq_set = 8'h00, dak_n, drq;
  logic [4:0] slow = 5'h00;
  isb_req_t req = '0;
  isb_rsp_t rsp;
  logic req_ready, rsp_valid, dma_done, irq_valid, sys_err, bclk, resdrv, bale, aen, sbhe_n;
  logic iorc_n, iowc_n, mrdc_n, mwtc_n, d_oe_n, chrdy, io16_n;
  logic [2:0] dma_chan;
  logic [3:0] irq_num;
  logic [`ISB_SA_W-1:0] sa;
  logic [`ISB_AW-1:`ISB_LA_LO] la;
  int failures = 0, samples_checked = 0, cyc = 0;

  isb_host isb_host_i (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp(rsp), .rsp_valid(rsp_valid), .dma_addr(dma_addr),
    .dma_to_mem(dma_to_mem), .dma_done(dma_done), .dma_chan(dma_chan), .irq_valid(irq_valid),
    .irq_num(irq_num), .irq_ack(irq_ack), .sys_err(sys_err), .err_clr(err_clr), .bclk(bclk),
    .resdrv(resdrv), .bale(bale), .aen(aen), .sa(sa), .la(la), .sbhe_n(sbhe_n),
    .iorc_n(iorc_n), .iowc_n(iowc_n), .mrdc_n(mrdc_n), .mwtc_n(mwtc_n), .dak_n(dak_n),
    .d_out(d_out), .d_oe_n(d_oe_n), .d_in(d_in), .chrdy(chrdy), .io16_n(io16_n),
    .iochk_n(iochk_n), .drq(drq), .irq(irq));
  isb_card isb_card_i (.clk_sys(clk_sys), .sa(sa), .sbhe_n(sbhe_n), .aen(aen),
    .iorc_n(iorc_n), .iowc_n(iowc_n), .mrdc_n(mrdc_n), .mwtc_n(mwtc_n), .d_out(d_out),
    .dak_n(dak_n), .slow(slow), .drq_set(drq_set), .d_in(d_in), .chrdy(chrdy),
    .io16_n(io16_n), .drq(drq));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic xfer(input logic wr, io, wide, input logic [23:0] a, input logic [15:0] d,
                      output logic [15:0] q, output int lo);
    int n;
    req <= '{wr, io, wide, a, d};
    req_valid <= 1'b1;
    n = 0;
    do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 500);
    req_valid <= 1'b0;
    lo = 0;
    do begin
      @(posedge clk_sys);
      lo += ({iorc_n, iowc_n, mrdc_n, mwtc_n} != 4'hF);
    end while (rsp_valid !== 1'b1 && ++n < 3000);
    q = rsp.data;
  endtask : xfer

  task automatic t_io16();
    logic [15:0] q;
    int lo;
    xfer(1'b1, 1'b1, 1'b1, 24'h000300, 16'hA55A, q, lo);
    chk("io16 write strobe", 16'(lo), 16'(`ISB_CMD16_BCLKS * 8));
    xfer(1'b0, 1'b1, 1'b1, 24'h000300, 16'h0000, q, lo);
    chk("io16 read strobe", 16'(lo), 16'(`ISB_CMD16_BCLKS * 8));
    chk("io16 read data", q, 16'hA55A);
  endtask : t_io16

  task automatic t_split();
    logic [15:0] q;
    int lo;
    // card holds ready low past the base command length, so each byte is stretched
    slow <= 5'h04;
    xfer(1'b1, 1'b0, 1'b1, 24'hA41004, 16'hC33C, q, lo);
    chk("split low byte", {8'h00, isb_card_i.mem[4]}, 16'h003C);
    chk("split high byte", {8'h00, isb_card_i.mem[5]}, 16'h00C3);
    chk("stretch whole", 16'(lo % 8), 16'h0000);
    chk("stretch longer", 16'(lo > 2 * `ISB_CMD8_BCLKS * 8), 16'h0001);
    chk("upper address", 16'(la), 16'h0052);
    xfer(1'b0, 1'b0, 1'b1, 24'hA41004, 16'h0000, q, lo);
    chk("split read data", q, 16'hC33C);
    slow <= 5'h00;
  endtask : t_split

  task automatic t_dma();
    logic [2:0] exp_ch [4] = '{3'h1, 3'h5, 3'h6, 3'h7};
    logic sb;
    logic [3:0] st;
    int n;
    drq_set <= 8'hE2;
    @(posedge clk_sys);
    drq_set <= 8'h00;
    foreach (exp_ch[i]) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        if (dak_n != 8'hFF) sb = sbhe_n;
        if ({iorc_n, iowc_n, mrdc_n, mwtc_n} != 4'hF) st = {iorc_n, iowc_n, mrdc_n, mwtc_n};
      end while (dma_done !== 1'b1 && ++n < 500);
      chk("dma channel", 16'(dma_chan), 16'(exp_ch[i]));
      chk("dma width", 16'(sb), 16'(exp_ch[i] < 3'h4));
      chk("dma strobes", 16'(st), dma_to_mem ? 16'h0006 : 16'h0009);
      // alternate direction so both strobe pairs are exercised
      dma_to_mem <= !dma_to_mem;
    end
  endtask : t_dma

  task automatic t_irq();
    logic [3:0] exp_n [4] = '{4'h9, 4'hF, 4'h3, 4'h7};
    int n;
    irq <= 16'h8288;
    foreach (exp_n[i]) begin
      n = 0;
      do @(posedge clk_sys); while (irq_valid !== 1'b1 && ++n < 50);
      chk("irq number", 16'(irq_num), 16'(exp_n[i]));
      irq_ack <= 1'b1;
      irq[exp_n[i]] <= 1'b0;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
      @(posedge clk_sys);
    end
    chk("irq idle", 16'(irq_valid), 16'h0000);
  endtask : t_irq

  task automatic t_err();
    iochk_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    iochk_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("error latched", 16'(sys_err), 16'h0001);
    err_clr <= 1'b1;
    @(posedge clk_sys);
    err_clr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("error cleared", 16'(sys_err), 16'h0000);
  endtask : t_err

  task automatic t_fifo();
    int n, k;
    slow <= 5'h14;
    req <= '{1'b1, 1'b0, 1'b0, 24'h001008, 16'h0011};
    req_valid <= 1'b1;
    n = 0;
    k = 0;
    do begin
      @(posedge clk_sys);
      n += (req_ready === 1'b1);
    end while (req_ready === 1'b1 && ++k < 100);
    req_valid <= 1'b0;
    slow <= 5'h00;
    chk("fifo fill", 16'(n >= `ISB_FIFO_DEPTH && n <= `ISB_FIFO_DEPTH + 2), 16'h0001);
    k = 0;
    while (n > 0 && ++k < 20000) begin
      @(posedge clk_sys);
      n -= (rsp_valid === 1'b1);
    end
    chk("fifo drain", 16'(n), 16'h0000);
  endtask : t_fifo

  initial begin
    int n;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    n = 0;
    while (resdrv === 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk("reset drive length", 16'(n >= 99 && n <= 102), 16'h0001);
    t_io16();
    t_split();
    t_dma();
    t_irq();
    t_err();
    t_fifo();
    end_of_test();
  end
endmodule : isb_host_test

// File: include/isb_cfg.svh
`ifndef ISB_CFG_SVH
`define ISB_CFG_SVH

// ---------------------------------------------------------------
// widths and clocking
// ---------------------------------------------------------------
`define ISB_AW          24
`define ISB_DW          16
`define ISB_SA_W        20
`define ISB_LA_LO       17
`define ISB_CLK_MHZ     100
`define ISB_BCLK_NS     80
`define ISB_BCLK_HALF   ((`ISB_BCLK_NS * `ISB_CLK_MHZ) / 2000)
`define ISB_RESDRV_NS   1000
`define ISB_RESDRV_CYC  ((`ISB_RESDRV_NS * `ISB_CLK_MHZ + 999) / 1000)

// ---------------------------------------------------------------
// cycle shapes, in bus clock periods
// ---------------------------------------------------------------
`define ISB_CMD8_BCLKS  4
`define ISB_CMD16_BCLKS 2
`define ISB_DMA_BCLKS   2

// ---------------------------------------------------------------
// line masks, priority order and request queue depth
// ---------------------------------------------------------------
`define ISB_DRQ_MASK    8'hEF
`define ISB_IRQ_MASK    16'hDEF8
`define ISB_IRQ_ORDER   44'h9ABCEF34567
`define ISB_IRQ_COUNT   11
`define ISB_FIFO_DEPTH  32

`endif

// File: include/isb_pkg.sv
`include "isb_cfg.svh"

package isb_pkg;

  typedef struct packed {
    logic                 wr;
    logic                 io;
    logic                 wide;
    logic [`ISB_AW-1:0]   addr;
    logic [`ISB_DW-1:0]   data;
  } isb_req_t;

  typedef struct packed {
    logic [`ISB_DW-1:0]   data;
    logic                 chk;
  } isb_rsp_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_CMD  = 5'h04,
    ST_END  = 5'h08,
    ST_HOLD = 5'h10
  } isb_state_t;

endpackage : isb_pkg

// File: verilog/isb_fifo.sv
module isb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    full;
    logic                    ov;
    logic [W-1:0]            od;
  } isb_fifo_st_t;

  isb_fifo_st_t q;
  isb_fifo_st_t d;
  logic         push;
  logic         pop;

  // output word sits in a register; memory refills it when it drains
  always_comb begin
    d    = q;
    push = in_valid && !q.full;
    pop  = (q.cnt != '0) && (!q.ov || out_ready);
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = q.wp + 1'b1;
    end
    if (out_ready && q.ov) begin
      d.ov = 1'b0;
    end
    if (pop) begin
      d.od = q.mem[q.rp];
      d.ov = 1'b1;
      d.rp = q.rp + 1'b1;
    end
    d.cnt  = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    d.full = (d.cnt == (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready  = !q.full;
  assign out_valid = q.ov;
  assign out_data  = q.od;

endmodule : isb_fifo

// File: verilog/isb_host.sv
// How it works
// - during a dma cycle aen is high; dma owns address and command lines
// - bale high with valid address; its fall latches the processor address
// - bale stays high through the whole dma cycle
// - bus clock is a divided clock with equal high and low halves
// - ready low stretches the command by whole bus clock periods
// - on byte transfers the upper byte is steered onto the low lanes
// - a word transfer to a byte card becomes two byte transfers
// - a dma grant drives the matching acknowledge low; channels 0-3, 5-7
// - dma requests win by fixed priority, channel 0 highest, 7 lowest
// - channels 0-3 move bytes, channels 5-7 move words
// - io16 low marks a word io cycle, run with one wait state
// - channel check low is latched as an uncorrectable system error
// - io read strobe is active low and asks the card to drive data
// - io write strobe is active low and asks the card to take data
// - interrupts ranked 9-12,14,15 above 3-7; 9 highest, 7 lowest
// - an interrupt is a rising edge, held until acknowledged
// - upper unlatched address lines are driven while bale is high
`include "isb_cfg.svh"

module isb_host #(
  parameter int FIFO_DEPTH = `ISB_FIFO_DEPTH
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       req_valid,
  input  wire isb_pkg::isb_req_t          req,
  output logic                            req_ready,
  output isb_pkg::isb_rsp_t               rsp,
  output logic                            rsp_valid,
  input  wire logic [`ISB_AW-1:0]         dma_addr,
  input  wire logic                       dma_to_mem,
  output logic                            dma_done,
  output logic [2:0]                      dma_chan,
  output logic                            irq_valid,
  output logic [3:0]                      irq_num,
  input  wire logic                       irq_ack,
  output logic                            sys_err,
  input  wire logic                       err_clr,
  output logic                            bclk,
  output logic                            resdrv,
  output logic                            bale,
  output logic                            aen,
  output logic [`ISB_SA_W-1:0]            sa,
  output logic [`ISB_AW-1:`ISB_LA_LO]     la,
  output logic                            sbhe_n,
  output logic                            iorc_n,
  output logic                            iowc_n,
  output logic                            mrdc_n,
  output logic                            mwtc_n,
  output logic [7:0]                      dak_n,
  output logic [`ISB_DW-1:0]              d_out,
  output logic                            d_oe_n,
  input  wire logic [`ISB_DW-1:0]         d_in,
  input  wire logic                       chrdy,
  input  wire logic                       io16_n,
  input  wire logic                       iochk_n,
  input  wire logic [7:0]                 drq,
  input  wire logic [15:0]                irq
);

  import isb_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    isb_state_t                 fsm;
    logic [7:0]                 div;
    logic                       bclk;
    logic [7:0]                 rcnt;
    logic                       resdrv;
    logic                       bale;
    logic                       aen;
    logic [`ISB_SA_W-1:0]       sa;
    logic [`ISB_AW-1:`ISB_LA_LO] la;
    logic                       sbhe_n;
    logic                       iorc_n;
    logic                       iowc_n;
    logic                       mrdc_n;
    logic                       mwtc_n;
    logic [7:0]                 dak_n;
    logic [`ISB_DW-1:0]         d_out;
    logic                       d_oe_n;
    logic [3:0]                 cnt;
    logic                       half;
    logic                       wide16;
    logic                       dma;
    logic                       dma_done;
    logic [2:0]                 dma_chan;
    isb_req_t                   rq;
    logic [`ISB_DW-1:0]         rdata;
    logic                       rsp_valid;
    logic [15:0]                irq_prev;
    logic [15:0]                irq_pend;
    logic                       irq_valid;
    logic [3:0]                 irq_num;
    logic                       sys_err;
  } isb_host_st_t;

  isb_host_st_t       q;
  isb_host_st_t       d;
  isb_req_t           f_req;
  logic               f_valid;
  logic               pop;
  logic               rise;
  logic               w16;
  logic               dma_any;
  logic [2:0]         ch;
  logic [15:0]        irq_rise;
  logic [15:0]        irq_clr;
  logic [`ISB_AW-1:0] a1;
  logic [`ISB_DW-1:0] d_s;
  logic [26:0]        ctl_s;
  logic [7:0]         drq_s;
  logic [15:0]        irq_s;
  logic               chrdy_s;
  logic               io16_s_n;
  logic               iochk_s_n;

  // ---------------------------------------------------------------
  // priority pickers
  // ---------------------------------------------------------------
  function automatic logic [4:0] irq_pick(input logic [15:0] pend);
    logic [3:0] n;
    logic [4:0] r;
    r = 5'h00;
    for (int i = `ISB_IRQ_COUNT - 1; i >= 0; i--) begin
      n = 4'(`ISB_IRQ_ORDER >> (4 * (`ISB_IRQ_COUNT - 1 - i)));
      if (pend[n]) begin
        r = {1'b1, n};
      end
    end
    return r;
  endfunction : irq_pick

  function automatic logic [2:0] drq_pick(input logic [7:0] rq);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (rq[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : drq_pick

  // ---------------------------------------------------------------
  // request queue and pin synchronisers
  // ---------------------------------------------------------------
  isb_fifo #(
    .W     ($bits(isb_req_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (req_valid),
    .in_data   (req),
    .in_ready  (req_ready),
    .out_valid (f_valid),
    .out_data  (f_req),
    .out_ready (pop)
  );

  isb_sync #(
    .W       (`ISB_DW),
    .RST_VAL (16'h0000)
  ) u_sync_d (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (d_in),
    .sync_out (d_s)
  );

  isb_sync #(
    .W       (27),
    .RST_VAL (27'h0000007)
  ) u_sync_ctl (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({drq, irq, chrdy, io16_n, iochk_n}),
    .sync_out (ctl_s)
  );

  assign {drq_s, irq_s, chrdy_s, io16_s_n, iochk_s_n} = ctl_s;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    d.dma_done  = 1'b0;
    pop         = 1'b0;
    w16         = 1'b0;
    a1          = q.rq.addr + 24'h000001;
    rise        = (q.div == 8'(`ISB_BCLK_HALF - 1)) && !q.bclk;
    dma_any     = |(drq_s & `ISB_DRQ_MASK);
    ch          = drq_pick(drq_s & `ISB_DRQ_MASK);
    // bus clock toggles every half period
    if (q.div == 8'(`ISB_BCLK_HALF - 1)) begin
      d.div  = 8'h00;
      d.bclk = ~q.bclk;
    end else begin
      d.div = q.div + 8'h01;
    end
    if (q.rcnt != 8'h00) begin
      d.rcnt = q.rcnt - 8'h01;
    end
    d.resdrv = (q.rcnt != 8'h00);
    // interrupts: edge sets pending, acknowledge clears, set wins
    d.irq_prev = irq_s;
    irq_rise   = irq_s & ~q.irq_prev & `ISB_IRQ_MASK;
    irq_clr    = (irq_ack && q.irq_valid) ? (16'h0001 << q.irq_num) : 16'h0000;
    d.irq_pend = (q.irq_pend & ~irq_clr) | irq_rise;
    {d.irq_valid, d.irq_num} = irq_pick(d.irq_pend);
    d.sys_err = (q.sys_err && !err_clr) || !iochk_s_n;
    if (rise) begin
      unique case (q.fsm)
        ST_IDLE: begin
          if (!q.resdrv && dma_any) begin
            d.dma      = 1'b1;
            d.dma_chan = ch;
            d.dak_n    = ~(8'h01 << ch);
            d.aen      = 1'b1;
            d.bale     = 1'b1;
            d.sa       = dma_addr[`ISB_SA_W-1:0];
            d.la       = dma_addr[`ISB_AW-1:`ISB_LA_LO];
            d.sbhe_n   = ~ch[2];
            d.fsm      = ST_ADDR;
          end else if (!q.resdrv && f_valid) begin
            pop      = 1'b1;
            d.dma    = 1'b0;
            d.rq     = f_req;
            d.half   = 1'b0;
            d.rdata  = 16'h0000;
            d.bale   = 1'b1;
            d.sa     = f_req.addr[`ISB_SA_W-1:0];
            d.la     = f_req.addr[`ISB_AW-1:`ISB_LA_LO];
            d.sbhe_n = ~f_req.wide;
            d.fsm    = ST_ADDR;
          end
        end
        ST_ADDR: begin
          d.bale = q.dma;
          if (q.dma) begin
            w16      = q.dma_chan[2];
            d.iorc_n = !dma_to_mem;
            d.mwtc_n = !dma_to_mem;
            d.mrdc_n = dma_to_mem;
            d.iowc_n = dma_to_mem;
            d.cnt    = 4'(`ISB_DMA_BCLKS - 1);
          end else begin
            w16 = q.rq.io && q.rq.wide && !q.half && !io16_s_n && !q.sa[0];
            d.iorc_n = !(q.rq.io && !q.rq.wr);
            d.iowc_n = !(q.rq.io && q.rq.wr);
            d.mrdc_n = !(!q.rq.io && !q.rq.wr);
            d.mwtc_n = !(!q.rq.io && q.rq.wr);
            d.d_oe_n = !q.rq.wr;
            if (w16) begin
              d.d_out = q.rq.data;
              d.cnt   = 4'(`ISB_CMD16_BCLKS - 1);
            end else begin
              d.d_out = q.half ? {8'h00, q.rq.data[15:8]}
                               : {8'h00, q.rq.data[7:0]};
              d.cnt   = 4'(`ISB_CMD8_BCLKS - 1);
            end
          end
          d.wide16 = w16;
          d.fsm    = ST_CMD;
        end
        ST_CMD: begin
          if (q.cnt != 4'h0) begin
            d.cnt = q.cnt - 4'h1;
          end else if (chrdy_s) begin
            if (q.wide16) begin
              d.rdata = d_s;
            end else if (q.half) begin
              d.rdata[15:8] = d_s[7:0];
            end else begin
              d.rdata[7:0] = d_s[7:0];
            end
            d.iorc_n = 1'b1;
            d.iowc_n = 1'b1;
            d.mrdc_n = 1'b1;
            d.mwtc_n = 1'b1;
            d.d_oe_n = 1'b1;
            d.fsm    = ST_END;
          end
        end
        ST_END: begin
          if (q.dma) begin
            d.dak_n    = 8'hFF;
            d.aen      = 1'b0;
            d.bale     = 1'b0;
            d.dma      = 1'b0;
            d.sbhe_n   = 1'b1;
            d.dma_done = 1'b1;
            d.fsm      = ST_IDLE;
          end else if (q.rq.wide && !q.wide16 && !q.half) begin
            d.half = 1'b1;
            d.bale = 1'b1;
            d.sa   = a1[`ISB_SA_W-1:0];
            d.la   = a1[`ISB_AW-1:`ISB_LA_LO];
            d.fsm  = ST_ADDR;
          end else begin
            d.sbhe_n    = 1'b1;
            d.rsp_valid = 1'b1;
            d.fsm       = ST_IDLE;
          end
        end
        default: begin
          d.fsm = ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q        <= '0;
      q.fsm    <= ST_IDLE;
      q.rcnt   <= 8'(`ISB_RESDRV_CYC);
      q.resdrv <= 1'b1;
      q.sbhe_n <= 1'b1;
      q.iorc_n <= 1'b1;
      q.iowc_n <= 1'b1;
      q.mrdc_n <= 1'b1;
      q.mwtc_n <= 1'b1;
      q.dak_n  <= 8'hFF;
      q.d_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rsp       = '{data: q.rdata, chk: q.sys_err};
  assign rsp_valid = q.rsp_valid;
  assign dma_done  = q.dma_done;
  assign dma_chan  = q.dma_chan;
  assign irq_valid = q.irq_valid;
  assign irq_num   = q.irq_num;
  assign sys_err   = q.sys_err;
  assign bclk      = q.bclk;
  assign resdrv    = q.resdrv;
  assign bale      = q.bale;
  assign aen       = q.aen;
  assign sa        = q.sa;
  assign la        = q.la;
  assign sbhe_n    = q.sbhe_n;
  assign iorc_n    = q.iorc_n;
  assign iowc_n    = q.iowc_n;
  assign mrdc_n    = q.mrdc_n;
  assign mwtc_n    = q.mwtc_n;
  assign dak_n     = q.dak_n;
  assign d_out     = q.d_out;
  assign d_oe_n    = q.d_oe_n;

endmodule : isb_host

// File: verilog/isb_sync.sv
module isb_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } isb_sync_st_t;

  isb_sync_st_t q;
  isb_sync_st_t d;

  always_comb begin
    d      = q;
    d.meta = async_in;
    d.stab = q.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '{meta: RST_VAL, stab: RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stab;

endmodule : isb_sync
